// *** hw/acr_map.svh ***
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ==========================================
// register addresses
`define ACR_ADDR_PORT     13'h000
`define ACR_ADDR_ID       13'h001
`define ACR_ADDR_GRADE    13'h002
`define ACR_ADDR_CHSEL    13'h005
`define ACR_ADDR_XFER     13'h0ff
`define ACR_ADDR_FUNC_LO  13'h008
`define ACR_ADDR_FUNC_HI  13'h020
`define ACR_ADDR_SYNC     13'h03a
`define ACR_ADDR_ONE      13'h001

// ==========================================
// function register bank layout
`define ACR_N_FUNC        26
`define ACR_FUNC_W        208
`define ACR_IDX_SYNC      5'h19
`define ACR_IDX_CLOCK     1
`define ACR_IDX_OUTMODE   12
`define ACR_LOCAL_MASK    26'h0000001

// ==========================================
// reset values and fields
`define ACR_DEF_ZERO      8'h00
`define ACR_DEF_CLOCK     8'h01
`define ACR_DEF_OUTMODE   8'h05
`define ACR_PORT_FIXED    8'h18
`define ACR_PORT_LSB_MASK 8'h42
`define ACR_PORT_SRST_MSK 8'h24
`define ACR_CHSEL_RST     2'h3
`define ACR_XFER_BIT      0
`define ACR_GRADE_LSB     4
`define ACR_RD_UNMAPPED   8'h00

// ==========================================
// serial framing
`define ACR_RNW_BIT       15
`define ACR_INSTR_LAST    4'hf
`define ACR_BYTE_LAST     4'h7
`define ACR_CNT_ZERO      4'h0
`define ACR_CNT_ONE       4'h1

`endif

// *** hw/acr_pkg.sv ***
`default_nettype none
package acr_pkg;
    // serial front-end frame phase
    typedef enum logic [1:0] {
        ACR_FE_IDLE,
        ACR_FE_INSTR,
        ACR_FE_DATA
    } acr_fe_state_t;
endpackage
`default_nettype wire

// *** hw/acr_shadow_byte.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"

module acr_shadow_byte #(
    parameter logic [7:0] RST_VAL = `ACR_DEF_ZERO
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       clr_i,
    // host write and commit
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       commit_i,
    // stored values
    output logic      [7:0] shadow_o,
    output logic      [7:0] work_o
);

    // a write and a commit in one cycle move the old shadow value
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || clr_i) begin
            shadow_o <= RST_VAL;
            work_o   <= RST_VAL;
        end else begin
            if (we_i) begin
                shadow_o <= wdata_i;
            end
            if (commit_i) begin
                work_o <= shadow_o;
            end
        end
    end

endmodule
`default_nettype wire

// *** hw/acr_serial_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"

module acr_serial_port (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // serial pins
    input  wire logic        sclk_i,
    input  wire logic        csb_b_i,
    input  wire logic        sdio_i,
    output logic             sdio_o,
    output logic             sdio_oe_b_o,
    // register side
    input  wire logic        lsb_first_i,
    input  wire logic [7:0]  rdata_i,
    output logic      [12:0] addr_o,
    output logic             wr_stb_o,
    output logic      [12:0] wr_addr_o,
    output logic      [7:0]  wdata_o
);

    // ==========================================
    // pin synchronisers
    logic [2:0] sclk_q;
    logic [2:0] csb_q;
    logic [2:0] sdio_q;
    logic       sclk_f;
    logic       csb_f;
    logic       sdio_f;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sclk_q <= 3'h0;
            csb_q  <= 3'h7;
            sdio_q <= 3'h0;
            sclk_f <= 1'b0;
            csb_f  <= 1'b1;
            sdio_f <= 1'b0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk_i};
            csb_q  <= {csb_q[1:0], csb_b_i};
            sdio_q <= {sdio_q[1:0], sdio_i};
            if (sclk_q[1] == sclk_q[2]) sclk_f <= sclk_q[2];
            if (csb_q[1] == csb_q[2]) csb_f <= csb_q[2];
            if (sdio_q[1] == sdio_q[2]) sdio_f <= sdio_q[2];
        end
    end

    wire logic sclk_agree = sclk_q[1] == sclk_q[2];
    wire logic sclk_rise  = sclk_agree && sclk_q[2] && !sclk_f;
    wire logic sclk_fall  = sclk_agree && !sclk_q[2] && sclk_f;
    wire logic bit_in     = (sdio_q[1] == sdio_q[2]) ? sdio_q[2] : sdio_f;

    // ==========================================
    // shifting
    acr_pkg::acr_fe_state_t state;
    logic [15:0] sr;
    logic [3:0]  cnt;
    logic        rnw;
    logic        byte_done;
    logic [7:0]  tx;

    // both orders assemble the same word
    wire logic [15:0] next_sr = lsb_first_i ? {bit_in, sr[15:1]}
                                            : {sr[14:0], bit_in};
    wire logic [7:0]  byte_in = lsb_first_i ? next_sr[15:8]
                                            : next_sr[7:0];
    wire logic [12:0] addr_step = lsb_first_i
                                  ? 13'(addr_o + `ACR_ADDR_ONE)
                                  : 13'(addr_o - `ACR_ADDR_ONE);
    wire logic [7:0]  next_tx = lsb_first_i ? {1'b0, tx[7:1]}
                                            : {tx[6:0], 1'b0};
    wire logic [7:0]  tx_src  = (cnt == `ACR_CNT_ZERO) ? rdata_i : next_tx;
    wire logic        tx_bit  = lsb_first_i ? tx_src[0] : tx_src[7];
    wire logic        cnt_wrap = cnt == `ACR_BYTE_LAST;
    wire logic [3:0]  cnt_inc = 4'(cnt + `ACR_CNT_ONE);

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || csb_f) begin
            state       <= acr_pkg::ACR_FE_IDLE;
            cnt         <= `ACR_CNT_ZERO;
            byte_done   <= 1'b0;
            wr_stb_o    <= 1'b0;
            sdio_oe_b_o <= 1'b1;
            if (!rst_b_i) begin
                sr        <= 16'h0000;
                rnw       <= 1'b0;
                tx        <= 8'h00;
                sdio_o    <= 1'b0;
                addr_o    <= 13'h0000;
                wr_addr_o <= 13'h0000;
                wdata_o   <= 8'h00;
            end
        end else begin
            byte_done <= 1'b0;
            wr_stb_o  <= 1'b0;
            // step after the strobe so the write sees its own address
            if (byte_done) addr_o <= addr_step;
            unique case (state)
                acr_pkg::ACR_FE_IDLE: begin
                    state <= acr_pkg::ACR_FE_INSTR;
                end
                acr_pkg::ACR_FE_INSTR: begin
                    if (sclk_rise) begin
                        sr <= next_sr;
                        if (cnt == `ACR_INSTR_LAST) begin
                            state  <= acr_pkg::ACR_FE_DATA;
                            rnw    <= next_sr[`ACR_RNW_BIT];
                            addr_o <= next_sr[12:0];
                            cnt    <= `ACR_CNT_ZERO;
                        end else begin
                            cnt <= cnt_inc;
                        end
                    end
                end
                acr_pkg::ACR_FE_DATA: begin
                    if (sclk_rise) begin
                        sr  <= next_sr;
                        cnt <= cnt_wrap ? `ACR_CNT_ZERO : cnt_inc;
                        if (cnt_wrap) begin
                            byte_done <= 1'b1;
                            wr_stb_o  <= !rnw;
                            wr_addr_o <= addr_o;
                            wdata_o   <= byte_in;
                        end
                    end
                    if (sclk_fall && rnw) begin
                        tx          <= tx_src;
                        sdio_o      <= tx_bit;
                        sdio_oe_b_o <= 1'b0;
                    end
                end
                default: begin
                    state <= acr_pkg::ACR_FE_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// *** hw/acr_regmap.sv ***
// Overview of operation
// - decode chip config, channel index/transfer and function regions
// - every location is one byte, bit 7 most significant
// - writes to 0x08..0x20 and 0x3A land in shadow only
// - writing 0x01 to 0xFF copies all shadows to working at once
// - transfer bit clears itself after the update
// - local registers per channel; write reaches each selected channel
// - host reads with one channel selected; both selected returns A
// - global registers written to both copies; channel select has no effect
// - reset loads every register with its default
// - output mode register resets to 0x05
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.svh"

module acr_regmap #(
    // value arbitrary, not a real part code
    parameter logic [7:0] PART_IDENTIFIER     = 8'h5a,
    parameter logic [1:0] SPEED_GRADE = 2'h0
) (
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_b_i,
    // serial pins
    input  wire logic                   sclk_i,
    input  wire logic                   csb_b_i,
    input  wire logic                   sdio_i,
    output logic                        sdio_o,
    output logic                        sdio_oe_b_o,
    // working function registers
    output logic      [`ACR_FUNC_W-1:0] func_work_a_o,
    output logic      [`ACR_FUNC_W-1:0] func_work_b_o,
    output logic                        commit_o
);

    localparam logic [`ACR_N_FUNC-1:0] LOCAL_MASK = `ACR_LOCAL_MASK;

    // ==========================================
    // serial front end
    logic [12:0] fe_addr;
    logic        wr_stb;
    logic [12:0] wr_addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        lsb_first;
    logic [1:0]  chan_sel;
    logic        xfer_bit;
    logic        soft_rst;

    acr_serial_port u_port (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .sclk_i      (sclk_i),
        .csb_b_i     (csb_b_i),
        .sdio_i      (sdio_i),
        .sdio_o      (sdio_o),
        .sdio_oe_b_o (sdio_oe_b_o),
        .lsb_first_i (lsb_first),
        .rdata_i     (rdata),
        .addr_o      (fe_addr),
        .wr_stb_o    (wr_stb),
        .wr_addr_o   (wr_addr),
        .wdata_o     (wdata)
    );

    // ==========================================
    // address decode
    function automatic logic is_func(input logic [12:0] a);
        is_func = (a >= `ACR_ADDR_FUNC_LO && a <= `ACR_ADDR_FUNC_HI)
                  || a == `ACR_ADDR_SYNC;
    endfunction

    function automatic logic [4:0] func_index(input logic [12:0] a);
        func_index = (a == `ACR_ADDR_SYNC) ? `ACR_IDX_SYNC
                                           : 5'(a - `ACR_ADDR_FUNC_LO);
    endfunction

    wire logic       wr_port  = wr_stb && wr_addr == `ACR_ADDR_PORT;
    wire logic       wr_chsel = wr_stb && wr_addr == `ACR_ADDR_CHSEL;
    wire logic       wr_xfer  = wr_stb && wr_addr == `ACR_ADDR_XFER;
    wire logic       wr_func  = wr_stb && is_func(wr_addr);
    wire logic [4:0] wr_idx   = func_index(wr_addr);

    wire logic       rd_port  = fe_addr == `ACR_ADDR_PORT;
    wire logic       rd_id    = fe_addr == `ACR_ADDR_ID;
    wire logic       rd_grade = fe_addr == `ACR_ADDR_GRADE;
    wire logic       rd_chsel = fe_addr == `ACR_ADDR_CHSEL;
    wire logic       rd_xfer  = fe_addr == `ACR_ADDR_XFER;
    wire logic       rd_func  = is_func(fe_addr);
    wire logic [4:0] rd_idx   = func_index(fe_addr);
    wire logic       rd_map   = rd_port || rd_id || rd_grade || rd_chsel
                                || rd_xfer || rd_func;

    // ==========================================
    // chip configuration and transfer
    // soft reset and transfer are strobes and never read back as one
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_port && |(wdata & `ACR_PORT_SRST_MSK);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || soft_rst) begin
            lsb_first <= 1'b0;
            chan_sel  <= `ACR_CHSEL_RST;
            xfer_bit  <= 1'b0;
        end else begin
            if (wr_port) begin
                lsb_first <= |(wdata & `ACR_PORT_LSB_MASK);
            end
            if (wr_chsel) begin
                chan_sel <= wdata[1:0];
            end
            // set on command, gone the cycle after the commit
            xfer_bit <= wr_xfer && wdata[`ACR_XFER_BIT];
        end
    end

    assign commit_o = xfer_bit;

    // ==========================================
    // shadowed function registers, one copy per channel
    logic [`ACR_FUNC_W-1:0] shad_a;
    logic [`ACR_FUNC_W-1:0] shad_b;

    for (genvar i = 0; i < `ACR_N_FUNC; i++) begin : g_func
        localparam logic [7:0] RV =
            (i == `ACR_IDX_CLOCK)   ? `ACR_DEF_CLOCK   :
            (i == `ACR_IDX_OUTMODE) ? `ACR_DEF_OUTMODE :
                                      `ACR_DEF_ZERO;
        // a global register keeps both copies equal
        wire logic hit  = wr_func && wr_idx == 5'(i);
        wire logic glob = !LOCAL_MASK[i];
        wire logic we_a = hit && (glob || chan_sel[0]);
        wire logic we_b = hit && (glob || chan_sel[1]);

        acr_shadow_byte #(
            .RST_VAL (RV)
        ) u_a (
            .core_clk_i (core_clk_i),
            .rst_b_i    (rst_b_i),
            .clr_i      (soft_rst),
            .we_i       (we_a),
            .wdata_i    (wdata),
            .commit_i   (xfer_bit),
            .shadow_o   (shad_a[i*8 +: 8]),
            .work_o     (func_work_a_o[i*8 +: 8])
        );

        acr_shadow_byte #(
            .RST_VAL (RV)
        ) u_b (
            .core_clk_i (core_clk_i),
            .rst_b_i    (rst_b_i),
            .clr_i      (soft_rst),
            .we_i       (we_b),
            .wdata_i    (wdata),
            .commit_i   (xfer_bit),
            .shadow_o   (shad_b[i*8 +: 8]),
            .work_o     (func_work_b_o[i*8 +: 8])
        );
    end

    // ==========================================
    // readback
    // copy B only when A alone is deselected; both set favours A
    wire logic       rd_local = rd_func && LOCAL_MASK[rd_idx];
    wire logic       rd_use_b = rd_local && !chan_sel[0]
                                && chan_sel[1];
    wire logic [7:0] rd_fa    = shad_a[{rd_idx, 3'b000} +: 8];
    wire logic [7:0] rd_fb    = shad_b[{rd_idx, 3'b000} +: 8];
    wire logic [7:0] rd_fbyte = rd_use_b ? rd_fb : rd_fa;
    wire logic [7:0] port_rd  = `ACR_PORT_FIXED
                                | (lsb_first ? `ACR_PORT_LSB_MASK
                                             : `ACR_DEF_ZERO);
    wire logic [7:0] grade_rd = 8'(SPEED_GRADE) << `ACR_GRADE_LSB;

    assign rdata = rd_port  ? port_rd
                 : rd_id    ? PART_IDENTIFIER
                 : rd_grade ? grade_rd
                 : rd_chsel ? 8'(chan_sel)
                 : rd_xfer  ? 8'(xfer_bit)
                 : rd_func  ? rd_fbyte
                 : `ACR_RD_UNMAPPED;

    // ==========================================
    // checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    unmapped_read_a: assert property (
        !rd_map |-> rdata == `ACR_RD_UNMAPPED
    ) else $error("unmapped read not zero");

    shadow_hold_a: assert property (
        wr_func && !xfer_bit
        |=> $stable(func_work_a_o) && $stable(func_work_b_o)
    ) else $error("working register moved without transfer");

    xfer_commit_a: assert property (
        wr_xfer && wdata[`ACR_XFER_BIT]
        |=> xfer_bit ##1 func_work_a_o == $past(shad_a)
            && func_work_b_o == $past(shad_b)
    ) else $error("transfer did not copy shadows");

    xfer_clear_a: assert property (
        xfer_bit && !wr_xfer |=> !xfer_bit [*2]
    ) else $error("transfer bit stuck");

    local_write_a: assert property (
        wr_func && LOCAL_MASK[wr_idx] && chan_sel == 2'h1
        |=> $stable(shad_b)
            && shad_a[{$past(wr_idx), 3'b000} +: 8] == $past(wdata)
    ) else $error("local write reached wrong channel");

    read_both_a: assert property (
        rd_local && chan_sel == 2'h3 |-> rdata == rd_fa
    ) else $error("dual select read not channel A");

    global_write_a: assert property (
        wr_func && !LOCAL_MASK[wr_idx]
        |=> shad_a[{$past(wr_idx), 3'b000} +: 8] == $past(wdata)
            && shad_b[{$past(wr_idx), 3'b000} +: 8] == $past(wdata)
    ) else $error("global write not shared");

    reset_defaults_a: assert property (
        @(posedge core_clk_i) disable iff (1'b0)
        !rst_b_i |=> chan_sel == `ACR_CHSEL_RST && !xfer_bit
            && func_work_a_o[`ACR_IDX_CLOCK*8 +: 8] == `ACR_DEF_CLOCK
    ) else $error("defaults not loaded");

    outmode_reset_a: assert property (
        @(posedge core_clk_i) disable iff (1'b0)
        !rst_b_i |=> func_work_a_o[`ACR_IDX_OUTMODE*8 +: 8]
            == `ACR_DEF_OUTMODE
            && func_work_b_o[`ACR_IDX_OUTMODE*8 +: 8] == `ACR_DEF_OUTMODE
    ) else $error("output mode default wrong");

    port_mirror_a: assert property (
        wr_port && !(|(wdata & `ACR_PORT_SRST_MSK))
        |=> port_rd == (`ACR_PORT_FIXED
            | (|($past(wdata) & `ACR_PORT_LSB_MASK) ? `ACR_PORT_LSB_MASK
                                                     : `ACR_DEF_ZERO))
    ) else $error("port setup mirror wrong");

    id_fixed_a: assert property (
        rd_id |-> rdata == PART_IDENTIFIER
    ) else $error("part code changed");

endmodule
`default_nettype wire

// *** bench/acr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// serial host, mode 0, one byte per frame
module acr_host_model (
    // clock
    input  wire logic core_clk_i,
    // device side of the data pin
    input  wire logic sdio_o_i,
    input  wire logic sdio_oe_b_i,
    // pins
    output logic      sclk_o,
    output logic      csb_b_o,
    output logic      sdio_w_o
);
    logic h_en;
    logic h_d;
    logic flt = 1'b0;

    initial begin
        sclk_o = 1'b0;
        csb_b_o = 1'b1;
        h_en = 1'b1;
        h_d = 1'b0;
    end

    // undriven line toggles so a stale bit cannot pass
    always @(negedge core_clk_i) flt <= ~flt;
    assign sdio_w_o = !sdio_oe_b_i ? sdio_o_i : (h_en ? h_d : flt);

    task automatic half();
        repeat (5) @(negedge core_clk_i);
    endtask

    task automatic xfer(input logic rd, input logic [12:0] a,
                        input logic [7:0] wd, input logic lsb,
                        output logic [7:0] q);
        logic [23:0] fr;
        int          k;
        fr = {rd, 2'b00, a, wd};
        q = 8'h00;
        @(negedge core_clk_i);
        csb_b_o = 1'b0;
        half();
        for (int i = 0; i < 24; i++) begin
            k = lsb ? (i < 16 ? 8 + i : i - 16) : 23 - i;
            sclk_o = 1'b0;
            h_en = !(rd && i > 15);
            h_d = fr[k];
            half();
            if (!h_en) q[k] = sdio_w_o;
            sclk_o = 1'b1;
            half();
        end
        sclk_o = 1'b0;
        half();
        csb_b_o = 1'b1;
        h_en = 1'b1;
        repeat (8) @(negedge core_clk_i);
    endtask
endmodule

`default_nettype wire

// *** bench/acr_regmap_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module acr_regmap_bench;
    // arbitrary value, not a real part code
    localparam logic [7:0] ID = 8'h3c;

    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic         sclk;
    logic         csb_b;
    logic         sdio_w;
    logic         sdio_o;
    logic         sdio_oe_b;
    logic [207:0] work_a;
    logic [207:0] work_b;
    logic         commit;
    logic         lsb_mode = 1'b0;
    int           commits = 0;
    int           err_total = 0;
    int           checks_done = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (commit === 1'b1) commits <= commits + 1;

    acr_regmap #(.PART_IDENTIFIER(ID), .SPEED_GRADE(2'h2)) i_dut (
        .core_clk_i    (clk),
        .rst_b_i       (rst_b),
        .sclk_i        (sclk),
        .csb_b_i       (csb_b),
        .sdio_i        (sdio_w),
        .sdio_o        (sdio_o),
        .sdio_oe_b_o   (sdio_oe_b),
        .func_work_a_o (work_a),
        .func_work_b_o (work_b),
        .commit_o      (commit)
    );

    acr_host_model i_host (
        .core_clk_i  (clk),
        .sdio_o_i    (sdio_o),
        .sdio_oe_b_i (sdio_oe_b),
        .sclk_o      (sclk),
        .csb_b_o     (csb_b),
        .sdio_w_o    (sdio_w)
    );

    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] ex,
                       input logic [7:0] got);
        checks_done++;
        if (got !== ex) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_host.xfer(1'b0, a, d, lsb_mode, q);
    endtask

    task automatic rdc(input logic [12:0] a, input logic [7:0] ex);
        logic [7:0] q;
        i_host.xfer(1'b1, a, 8'h00, lsb_mode, q);
        chk($sformatf("reg %h", a), ex, q);
    endtask

    task automatic commit_xfer();
        int n0;
        n0 = commits;
        wr(13'h0ff, 8'h01);
        chk("commit pulses", 8'h01, 8'(commits - n0));
    endtask

    function automatic logic [7:0] wa(int i);
        return work_a[8*i +: 8];
    endfunction

    function automatic logic [7:0] wb(int i);
        return work_b[8*i +: 8];
    endfunction

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk("work a 08", 8'h00, wa(0));
        chk("work a 09", 8'h01, wa(1));
        chk("work a 14", 8'h05, wa(12));
        chk("work b 14", 8'h05, wb(12));
        rdc(13'h000, 8'h18);
        rdc(13'h005, 8'h03);
        rdc(13'h0ff, 8'h00);
    endtask

    task automatic t_ident();
        rdc(13'h001, ID);
        wr(13'h001, 8'hff);
        rdc(13'h001, ID);
        rdc(13'h002, 8'h20);
        rdc(13'h003, 8'h00);
        rdc(13'h040, 8'h00);
    endtask

    task automatic t_shadow();
        wr(13'h014, 8'h01);
        wr(13'h03a, 8'h07);
        rdc(13'h014, 8'h01);
        chk("work a 14", 8'h05, wa(12));
        chk("work a 3a", 8'h00, wa(25));
        commit_xfer();
        chk("work a 14", 8'h01, wa(12));
        chk("work b 3a", 8'h07, wb(25));
        rdc(13'h0ff, 8'h00);
    endtask

    task automatic t_local();
        wr(13'h005, 8'h02);
        wr(13'h008, 8'h01);
        wr(13'h005, 8'h01);
        wr(13'h008, 8'h02);
        commit_xfer();
        chk("work a 08", 8'h02, wa(0));
        chk("work b 08", 8'h01, wb(0));
        rdc(13'h008, 8'h02);
        wr(13'h005, 8'h02);
        rdc(13'h008, 8'h01);
        wr(13'h005, 8'h03);
        rdc(13'h008, 8'h02);
        wr(13'h008, 8'h21);
        commit_xfer();
        chk("work a 08", 8'h21, wa(0));
        chk("work b 08", 8'h21, wb(0));
    endtask

    task automatic t_global();
        wr(13'h005, 8'h02);
        wr(13'h009, 8'h00);
        commit_xfer();
        chk("work a 09", 8'h00, wa(1));
        chk("work b 09", 8'h00, wb(1));
        wr(13'h005, 8'h01);
        rdc(13'h009, 8'h00);
    endtask

    // soft reset also drops the shift order back to msb first
    task automatic t_order();
        wr(13'h000, 8'h5a);
        lsb_mode = 1'b1;
        rdc(13'h000, 8'h5a);
        wr(13'h014, 8'h04);
        rdc(13'h014, 8'h04);
        wr(13'h000, 8'h3c);
        lsb_mode = 1'b0;
        rdc(13'h000, 8'h18);
        rdc(13'h014, 8'h05);
        rdc(13'h005, 8'h03);
        chk("work a 14", 8'h05, wa(12));
        chk("work a 09", 8'h01, wa(1));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        t_reset();
        t_ident();
        t_shadow();
        t_local();
        t_global();
        t_order();
        tally_and_finish();
    end

    // about 40 frames of some 260 cycles each, with margin
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule

`default_nettype wire
